// [hdl/asf_pkg.sv]
// constants and types shared by the serial frame and power control block
package asf_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [1:0]  CONFIG_WORD_OFFSET  = 2'h0;
	localparam logic [1:0]  REF_DAC_OFFSET      = 2'h2;
	localparam logic [15:0] CONFIG_WORD_RESET   = 16'h0000;
	localparam logic [8:0]  REF_LEVEL_RESET     = 9'h1ff;

	// ------------------------------------------------------------
	// command codes in bits 15:12 of the input word
	// ------------------------------------------------------------
	localparam logic [3:0]  CMD_CONFIG_WRITE    = 4'h8;
	localparam logic [3:0]  CMD_REF_A_WRITE     = 4'h9;
	localparam logic [3:0]  CMD_REF_B_WRITE     = 4'ha;

	// ------------------------------------------------------------
	// input word field positions
	// ------------------------------------------------------------
	localparam int          CMD_MSB             = 15;
	localparam int          CMD_LSB             = 12;
	localparam int          READOUT_CLOCK_BIT   = 11;
	localparam int          OUTPUT_LANE_BIT     = 10;
	localparam int          REF_SELECT_BIT      = 6;
	localparam int          LIGHT_SLEEP_BIT     = 5;
	localparam int          REF_LEVEL_MSB       = 11;
	localparam int          REF_LEVEL_LSB       = 3;

	// ------------------------------------------------------------
	// frame edge counts
	// ------------------------------------------------------------
	localparam logic [6:0]  EDGES_DUAL          = 7'h20;
	localparam logic [6:0]  EDGES_SINGLE        = 7'h30;
	localparam logic [6:0]  EDGES_POWER         = 7'h30;
	localparam logic [6:0]  EDGE_A_MSB          = 7'h10;
	localparam logic [6:0]  EDGE_B_MSB          = 7'h20;
	localparam logic [6:0]  EDGE_TAIL           = 7'h30;
	localparam logic [6:0]  EDGE_MAX            = 7'h7f;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ             = 125;
	localparam int          LIGHT_WAKE_NS       = 1000;
	localparam int          DEEP_WAKE_NS        = 10000;
	localparam int          LIGHT_WAKE_CYC      = (LIGHT_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int          DEEP_WAKE_CYC       = (DEEP_WAKE_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_NORMAL = 2'b00,
		PWR_LIGHT  = 2'b01,
		PWR_DEEP   = 2'b10
	} asf_power_e;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} asf_sample_s;

endpackage : asf_pkg

// [hdl/asf_frame_ctrl.sv]
// serial frame, readout and power mode logic of the dual converter
`timescale 1ns/10ps
`default_nettype none

module asf_frame_ctrl #(
	parameter int LIGHT_WAKE_CYCLES = asf_pkg::LIGHT_WAKE_CYC,
	parameter int DEEP_WAKE_CYCLES  = asf_pkg::DEEP_WAKE_CYC
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                chip_select_n,
	input  wire logic                serial_clk,
	input  wire logic                serial_in,
	input  wire asf_pkg::asf_sample_s result_data,
	input  wire logic                result_valid,
	output logic                     result_ready,
	output logic                     serial_out_a,
	output logic                     serial_out_a_oe,
	output logic                     serial_out_b,
	output logic                     serial_out_b_oe,
	output logic [15:0]              config_word_reg,
	output logic [8:0]               ref_level_a,
	output logic [8:0]               ref_level_b,
	output logic                     light_sleep_mode,
	output logic                     deep_power_down,
	output logic                     reference_powered,
	output logic                     circuits_ready,
	output logic                     sample_start
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 cs_s1;
		logic                 cs_s2;
		logic                 cs_s3;
		logic                 sclk_s1;
		logic                 sclk_s2;
		logic                 sclk_s3;
		logic                 sdi_s1;
		logic                 sdi_s2;
		logic                 in_frame;
		logic                 frame_single;
		logic [6:0]           edge_cnt;
		logic [15:0]          shift_in;
		logic                 sdi_all_hi;
		logic                 sdi_all_lo;
		logic [15:0]          cfg;
		logic [8:0]           ref_a;
		logic [8:0]           ref_b;
		asf_pkg::asf_power_e  mode;
		logic [13:0]          wake_cnt;
		asf_pkg::asf_sample_s cur;
		logic                 out_a;
		logic                 out_a_oe;
		logic                 out_b;
		logic                 out_b_oe;
		logic [1:0][31:0]     fifo;
		logic                 wr_ptr;
		logic                 rd_ptr;
		logic [1:0]           fill;
		logic                 start;
	} asf_state_s;

	asf_state_s r;
	asf_state_s r_nxt;

	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;

	assign cs_fall   = r.cs_s3 & ~r.cs_s2;
	assign cs_rise   = ~r.cs_s3 & r.cs_s2;
	assign sclk_fall = r.sclk_s3 & ~r.sclk_s2 & r.in_frame & ~cs_rise;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [6:0]  k;
		logic [6:0]  need;
		logic        valid;
		logic        push;
		logic        pop;
		logic [3:0]  cmd;
		logic [15:0] w;

		r_nxt = r;
		k     = 7'h00;
		need  = asf_pkg::EDGES_DUAL;
		valid = 1'b0;
		push  = result_valid && (r.fill != 2'd2);
		pop   = 1'b0;
		w     = r.shift_in;
		cmd   = w[asf_pkg::CMD_MSB:asf_pkg::CMD_LSB];

		r_nxt.cs_s1   = chip_select_n;
		r_nxt.cs_s2   = r.cs_s1;
		r_nxt.cs_s3   = r.cs_s2;
		r_nxt.sclk_s1 = serial_clk;
		r_nxt.sclk_s2 = r.sclk_s1;
		r_nxt.sclk_s3 = r.sclk_s2;
		r_nxt.sdi_s1  = serial_in;
		r_nxt.sdi_s2  = r.sdi_s1;
		r_nxt.start   = 1'b0;

		if (r.wake_cnt != 14'h0000) begin
			r_nxt.wake_cnt = r.wake_cnt - 14'h0001;
		end

		if (cs_fall) begin
			r_nxt.in_frame     = 1'b1;
			r_nxt.edge_cnt     = 7'h00;
			r_nxt.sdi_all_hi   = 1'b1;
			r_nxt.sdi_all_lo   = 1'b1;
			r_nxt.frame_single = r.cfg[asf_pkg::OUTPUT_LANE_BIT]
				& ~r.cfg[asf_pkg::READOUT_CLOCK_BIT];
			if (r.fill != 2'd0) begin
				pop   = 1'b1;
				r_nxt.cur = r.fifo[r.rd_ptr];
			end
			case (r.mode)
				asf_pkg::PWR_LIGHT: begin
					r_nxt.out_a    = 1'b1;
					r_nxt.out_b    = 1'b1;
					r_nxt.out_a_oe = 1'b1;
					r_nxt.out_b_oe = 1'b1;
				end
				asf_pkg::PWR_DEEP: begin
					r_nxt.out_a_oe = 1'b0;
					r_nxt.out_b_oe = 1'b0;
				end
				default: begin
					r_nxt.out_a    = 1'b0;
					r_nxt.out_b    = 1'b0;
					r_nxt.out_a_oe = 1'b1;
					r_nxt.out_b_oe = ~(r.cfg[asf_pkg::OUTPUT_LANE_BIT]
						& ~r.cfg[asf_pkg::READOUT_CLOCK_BIT]);
				end
			endcase
		end else if (cs_rise && r.in_frame) begin
			r_nxt.in_frame = 1'b0;
			r_nxt.out_a_oe = 1'b0;
			r_nxt.out_b_oe = 1'b0;
			need  = r.frame_single ? asf_pkg::EDGES_SINGLE : asf_pkg::EDGES_DUAL;
			valid = r.edge_cnt >= need;
			r_nxt.start = r.mode != asf_pkg::PWR_DEEP;
			case (r.mode)
				asf_pkg::PWR_NORMAL: begin
					if (r.edge_cnt >= asf_pkg::EDGES_POWER && r.sdi_all_hi) begin
						r_nxt.mode = asf_pkg::PWR_DEEP;
					end else if (valid && cmd == asf_pkg::CMD_CONFIG_WRITE) begin
						r_nxt.cfg = w;
						r_nxt.cfg[asf_pkg::LIGHT_SLEEP_BIT] = 1'b0;
						if (w[asf_pkg::LIGHT_SLEEP_BIT]) begin
							r_nxt.mode = asf_pkg::PWR_LIGHT;
						end
					end else if (valid && cmd == asf_pkg::CMD_REF_A_WRITE) begin
						r_nxt.ref_a = w[asf_pkg::REF_LEVEL_MSB:asf_pkg::REF_LEVEL_LSB];
					end else if (valid && cmd == asf_pkg::CMD_REF_B_WRITE) begin
						r_nxt.ref_b = w[asf_pkg::REF_LEVEL_MSB:asf_pkg::REF_LEVEL_LSB];
					end
				end
				asf_pkg::PWR_LIGHT: begin
					if (r.edge_cnt >= asf_pkg::EDGES_POWER && r.sdi_all_hi) begin
						r_nxt.mode = asf_pkg::PWR_DEEP;
					end else if (r.edge_cnt >= asf_pkg::EDGES_SINGLE
						&& cmd == asf_pkg::CMD_CONFIG_WRITE
						&& !w[asf_pkg::LIGHT_SLEEP_BIT]) begin
						r_nxt.cfg      = w;
						r_nxt.mode     = asf_pkg::PWR_NORMAL;
						r_nxt.wake_cnt = 14'(LIGHT_WAKE_CYCLES);
					end
				end
				default: begin
					if (r.edge_cnt >= asf_pkg::EDGES_POWER && r.sdi_all_lo) begin
						r_nxt.mode     = asf_pkg::PWR_NORMAL;
						r_nxt.wake_cnt = 14'(DEEP_WAKE_CYCLES);
					end
				end
			endcase
		end else if (sclk_fall) begin
			if (r.edge_cnt != asf_pkg::EDGE_MAX) begin
				r_nxt.edge_cnt = r.edge_cnt + 7'h01;
			end
			k = r.edge_cnt + 7'h01;
			if (r.edge_cnt < 7'h10) begin
				r_nxt.shift_in = {r.shift_in[14:0], r.sdi_s2};
			end
			r_nxt.sdi_all_hi = r.sdi_all_hi & r.sdi_s2;
			r_nxt.sdi_all_lo = r.sdi_all_lo & ~r.sdi_s2;
			if (r.mode == asf_pkg::PWR_NORMAL) begin
				r_nxt.out_a = 1'b0;
				r_nxt.out_b = 1'b0;
				if (k >= asf_pkg::EDGE_A_MSB && k < asf_pkg::EDGE_B_MSB) begin
					r_nxt.out_a = r.cur.a[4'(7'd31 - k)];
					r_nxt.out_b = r.cur.b[4'(7'd31 - k)];
				end else if (k >= asf_pkg::EDGE_B_MSB && k < asf_pkg::EDGE_TAIL
					&& r.frame_single) begin
					r_nxt.out_a = r.cur.b[4'(7'd47 - k)];
				end
			end
		end

		if (push) begin
			r_nxt.fifo[r.wr_ptr] = {result_data.a, result_data.b};
			r_nxt.wr_ptr = ~r.wr_ptr;
		end
		if (pop) begin
			r_nxt.rd_ptr = ~r.rd_ptr;
		end
		r_nxt.fill = r.fill + {1'b0, push} - {1'b0, pop};
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r            <= '0;
			r.cs_s1      <= 1'b1;
			r.cs_s2      <= 1'b1;
			r.cs_s3      <= 1'b1;
			r.cfg        <= asf_pkg::CONFIG_WORD_RESET;
			r.ref_a      <= asf_pkg::REF_LEVEL_RESET;
			r.ref_b      <= asf_pkg::REF_LEVEL_RESET;
			r.mode       <= asf_pkg::PWR_NORMAL;
		end else begin
			r <= r_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign result_ready      = r.fill != 2'd2;
	assign serial_out_a      = r.out_a;
	assign serial_out_a_oe   = r.out_a_oe;
	assign serial_out_b      = r.out_b;
	assign serial_out_b_oe   = r.out_b_oe;
	assign config_word_reg   = r.cfg;
	assign ref_level_a       = r.ref_a;
	assign ref_level_b       = r.ref_b;
	assign light_sleep_mode  = r.mode == asf_pkg::PWR_LIGHT;
	assign deep_power_down   = r.mode == asf_pkg::PWR_DEEP;
	assign reference_powered = (r.mode == asf_pkg::PWR_NORMAL)
		| ((r.mode == asf_pkg::PWR_LIGHT) & r.cfg[asf_pkg::REF_SELECT_BIT]);
	assign circuits_ready    = (r.mode == asf_pkg::PWR_NORMAL) & (r.wake_cnt == 14'h0000);
	assign sample_start      = r.start;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_lane_b_off: assert property (
		r.in_frame && r.frame_single && r.mode != asf_pkg::PWR_LIGHT |-> !r.out_b_oe
	) else $error("lane b driven in single-output frame");

	chk_cs_fall_zero: assert property (
		cs_fall && r.mode == asf_pkg::PWR_NORMAL |=> r.out_a_oe && !r.out_a
	) else $error("lane a not driving zero after select");

	chk_cs_rise_float: assert property (
		cs_rise && r.in_frame |=> !r.out_a_oe && !r.out_b_oe
	) else $error("outputs still driven after deselect");

	chk_light_ones: assert property (
		r.in_frame && r.mode == asf_pkg::PWR_LIGHT && !cs_rise |=> !r.in_frame
			|| (r.out_a && r.out_b && r.out_a_oe && r.out_b_oe)
	) else $error("light sleep outputs not all ones");

	chk_deep_float: assert property (
		r.mode == asf_pkg::PWR_DEEP |-> !r.out_a_oe && !r.out_b_oe
	) else $error("output driven in deep power down");

	chk_abort_keep: assert property (
		cs_rise && r.in_frame && r.edge_cnt < asf_pkg::EDGES_DUAL
			|=> $stable(r.cfg) && $stable(r.mode) && $stable(r.ref_a)
	) else $error("aborted frame changed configuration");

	chk_msb_edge: assert property (
		sclk_fall && r.edge_cnt == 7'h0f && r.mode == asf_pkg::PWR_NORMAL
			|=> r.out_a == r.cur.a[15]
	) else $error("converter a msb not on edge 16");

	chk_tail_zero: assert property (
		sclk_fall && r.edge_cnt == 7'h2f && r.mode == asf_pkg::PWR_NORMAL
			|=> !r.out_a
	) else $error("edge 48 not zero");

	chk_resample: assert property (
		cs_rise && r.in_frame && r.mode != asf_pkg::PWR_DEEP |=> sample_start ##1 !sample_start
	) else $error("sampling not restarted at frame end");

	chk_light_enter: assert property (
		cs_rise && r.in_frame && r.mode == asf_pkg::PWR_NORMAL
			&& r.edge_cnt >= asf_pkg::EDGES_SINGLE
			&& r.shift_in[asf_pkg::CMD_MSB:asf_pkg::CMD_LSB] == asf_pkg::CMD_CONFIG_WRITE
			&& r.shift_in[asf_pkg::LIGHT_SLEEP_BIT]
			|=> r.mode == asf_pkg::PWR_LIGHT
	) else $error("light sleep not entered after valid write");

	chk_light_wake: assert property (
		cs_rise && r.in_frame && r.mode == asf_pkg::PWR_LIGHT
			&& r.edge_cnt >= asf_pkg::EDGES_SINGLE
			&& r.shift_in[asf_pkg::CMD_MSB:asf_pkg::CMD_LSB] == asf_pkg::CMD_CONFIG_WRITE
			&& !r.shift_in[asf_pkg::LIGHT_SLEEP_BIT]
			|=> r.mode == asf_pkg::PWR_NORMAL && r.cfg == $past(r.shift_in)
	) else $error("light sleep wake write not applied");

	chk_deep_enter: assert property (
		cs_rise && r.in_frame && r.mode != asf_pkg::PWR_DEEP
			&& r.edge_cnt >= asf_pkg::EDGES_POWER && r.sdi_all_hi
			|=> r.mode == asf_pkg::PWR_DEEP
	) else $error("deep power down not entered");

	chk_deep_wake: assert property (
		cs_rise && r.in_frame && r.mode == asf_pkg::PWR_DEEP
			&& r.edge_cnt >= asf_pkg::EDGES_POWER && r.sdi_all_lo
			|=> r.mode == asf_pkg::PWR_NORMAL && !circuits_ready
	) else $error("deep power down wake not started");

endmodule : asf_frame_ctrl

`default_nettype wire

// [dv/asf_host_model.sv]
// host controller model driving chip select, serial clock and serial input
`timescale 1ns/10ps
`default_nettype none

module asf_host_model (
	input  wire logic clk,
	input  wire logic serial_out_a,
	input  wire logic serial_out_a_oe,
	input  wire logic serial_out_b,
	input  wire logic serial_out_b_oe,
	output logic      chip_select_n,
	output logic      serial_clk,
	output logic      serial_in
);
	initial begin
		chip_select_n = 1'b1;
		serial_clk    = 1'b1;
		serial_in     = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// undriven lanes read as z
	task automatic grab(inout logic [63:0] ca, inout logic [63:0] cb, input int k);
		ca[k] = serial_out_a_oe ? serial_out_a : 1'bz;
		cb[k] = serial_out_b_oe ? serial_out_b : 1'bz;
	endtask : grab

	// word msb first, then fill level; serial clock idles high between frames
	task automatic frame(input logic [15:0] word, input logic fill, input int n,
		output logic [63:0] ca, output logic [63:0] cb);
		ca = '0;
		cb = '0;
		tick(1);
		chip_select_n = 1'b0;
		tick(8);
		grab(ca, cb, 0);
		for (int k = 1; k <= n; k++) begin
			serial_in = (k <= 16) ? word[16 - k] : fill;
			tick(4);
			serial_clk = 1'b0;
			tick(4);
			serial_clk = 1'b1;
			tick(3);
			grab(ca, cb, k);
		end
		chip_select_n = 1'b1;
		tick(6);
		grab(ca, cb, 63);
	endtask : frame
endmodule : asf_host_model

`default_nettype wire

// [dv/adc_serial_frame_power_ctrl_tb_top.sv]
// self-checking bench of the serial frame and power control block
`timescale 1ns/10ps
`default_nettype none

module adc_serial_frame_power_ctrl_tb_top;
	logic                 clk = 1'b0;
	logic                 reset_n;
	logic                 chip_select_n, serial_clk, serial_in;
	asf_pkg::asf_sample_s result_data;
	logic                 result_valid, result_ready;
	logic                 out_a, oe_a, out_b, oe_b;
	logic [15:0]          config_word_reg;
	logic [8:0]           ref_level_a, ref_level_b;
	logic                 light_sleep_mode, deep_power_down, reference_powered;
	logic                 circuits_ready, sample_start;
	int                   num_errors = 0;
	int                   total_checks = 0;
	int                   cycles = 0;
	int                   starts = 0;
	logic [31:0]          lfsr = 32'h00000029;
	asf_pkg::asf_sample_s q[$];
	asf_pkg::asf_sample_s cur;
	logic [15:0]          cfg_m = asf_pkg::CONFIG_WORD_RESET;
	logic [8:0]           ra_m = asf_pkg::REF_LEVEL_RESET;
	logic [8:0]           rb_m = asf_pkg::REF_LEVEL_RESET;
	int                   mode_m = 0; // 0 normal, 1 light sleep, 2 deep

	always #4 clk = ~clk;

	asf_frame_ctrl #(.LIGHT_WAKE_CYCLES(4), .DEEP_WAKE_CYCLES(8)) dut_u (
		.clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
		.serial_clk(serial_clk), .serial_in(serial_in), .result_data(result_data),
		.result_valid(result_valid), .result_ready(result_ready),
		.serial_out_a(out_a), .serial_out_a_oe(oe_a), .serial_out_b(out_b),
		.serial_out_b_oe(oe_b), .config_word_reg(config_word_reg),
		.ref_level_a(ref_level_a), .ref_level_b(ref_level_b),
		.light_sleep_mode(light_sleep_mode), .deep_power_down(deep_power_down),
		.reference_powered(reference_powered), .circuits_ready(circuits_ready),
		.sample_start(sample_start)
	);

	asf_host_model host_u (
		.clk(clk), .serial_out_a(out_a), .serial_out_a_oe(oe_a), .serial_out_b(out_b),
		.serial_out_b_oe(oe_b), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
		.serial_in(serial_in)
	);

	// ------------------------------------------------------------
	// result stream, timeout and frame-end pulses
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	always @(posedge clk) begin
		cycles++;
		if (sample_start === 1'b1) begin
			starts++;
		end
		if (cycles == 30000) begin
			num_errors++;
			report_and_stop();
		end
	end

	always @(posedge clk) begin
		if (reset_n === 1'b1 && result_valid === 1'b1 && result_ready === 1'b1) begin
			q.push_back(result_data);
			lfsr = lfsr_next(lfsr);
			#1 result_data = lfsr;
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// one frame against the reference model
	// ------------------------------------------------------------
	task automatic run(input logic [15:0] w, input logic fill, input int n);
		logic [63:0] ca, cb, ea, eb;
		int          need, st;
		ea = '0;
		eb = '0;
		if (q.size() > 0) begin
			cur = q.pop_front();
		end
		for (int k = 0; k <= n; k++) begin
			if (mode_m == 2) begin
				ea[k] = 1'bz;
				eb[k] = 1'bz;
			end else if (mode_m == 1) begin
				ea[k] = 1'b1;
				eb[k] = 1'b1;
			end else if (cfg_m[10] && !cfg_m[11]) begin
				eb[k] = 1'bz;
				if (k >= 16 && k < 32) ea[k] = cur.a[31 - k];
				if (k >= 32 && k < 48) ea[k] = cur.b[47 - k];
			end else if (k >= 16 && k < 32) begin
				ea[k] = cur.a[31 - k];
				eb[k] = cur.b[31 - k];
			end
		end
		ea[63] = 1'bz;
		eb[63] = 1'bz;
		need = (mode_m == 0 && !(cfg_m[10] && !cfg_m[11])) ? 32 : 48;
		st = starts;
		host_u.frame(w, fill, n, ca, cb);
		check(ca, ea);
		check(cb, eb);
		check(64'(starts - st), (mode_m == 2) ? 64'h0 : 64'h1);
		if (n >= need) begin
			if (mode_m == 2) begin
				if (w == 16'h0000 && !fill) mode_m = 0;
			end else if (w == 16'hffff && fill) begin
				mode_m = 2;
			end else if (w[15:12] == asf_pkg::CMD_CONFIG_WRITE && (mode_m == 0 || !w[5])) begin
				cfg_m = w & 16'hffdf;
				mode_m = w[5] ? 1 : 0;
			end else if (mode_m == 0 && w[15:12] == asf_pkg::CMD_REF_A_WRITE) begin
				ra_m = w[11:3];
			end else if (mode_m == 0 && w[15:12] == asf_pkg::CMD_REF_B_WRITE) begin
				rb_m = w[11:3];
			end
		end
		check(config_word_reg, cfg_m);
		check({ref_level_a, ref_level_b}, {ra_m, rb_m});
		check({light_sleep_mode, deep_power_down, reference_powered},
			{mode_m == 1, mode_m == 2, mode_m == 0 || (mode_m == 1 && cfg_m[6])});
	endtask : run

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		result_valid = 1'b1;
		result_data = lfsr;
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(result_ready, 1'b0);
		check(config_word_reg, asf_pkg::CONFIG_WORD_RESET);
		run(16'h0000, 1'b0, 32);
		run(16'h9ab8, 1'b0, 32);
		run(16'ha3f0, 1'b0, 32);
		run(16'h8400, 1'b0, 32);
		run(16'h0000, 1'b0, 48);
		run(16'h8000, 1'b0, 40);
		result_valid = 1'b0;
		run(16'h8460, 1'b0, 48);
		run(16'h0000, 1'b0, 48);
		run(16'h8440, 1'b0, 40);
		run(16'h8480, 1'b0, 48);
		repeat (12) @(posedge clk);
		#1;
		check(circuits_ready, 1'b1);
		run(16'h0000, 1'b0, 48);
		run(16'hffff, 1'b1, 48);
		check(circuits_ready, 1'b0);
		run(16'hffff, 1'b1, 48);
		run(16'h0000, 1'b0, 48);
		check(circuits_ready, 1'b0);
		repeat (12) @(posedge clk);
		#1;
		check(circuits_ready, 1'b1);
		run(16'h8400, 1'b0, 48);
		run(16'h0000, 1'b0, 48);
		report_and_stop();
	end
endmodule : adc_serial_frame_power_ctrl_tb_top

`default_nettype wire
